// File: design/cfhs_blank.sv
`timescale 1ns/1ns
`include "cfhs_params.svh"
// Leading edge blanking of both current comparators
module cfhs_blank #(
  parameter int BLANK_CYC = `CFHS_BLANK_CYC
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic gate_edge,
  input  wire logic pwm_cmp,
  input  wire logic oc_cmp,
  output logic      pwm_cmp_q,
  output logic      oc_cmp_q
);
  localparam int CW = $clog2(BLANK_CYC + 1);
  initial begin
    if (BLANK_CYC < 1) $error("BLANK_CYC must be at least 1");
  end
  logic [CW-1:0] cnt;
  logic          edge_d;
  logic          blanking;
  assign blanking = (cnt != '0);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt    <= '0;
      edge_d <= 1'b0;
    end else begin
      edge_d <= gate_edge;
      if (gate_edge && !edge_d) begin
        cnt <= CW'(BLANK_CYC); // RULE14
      end else if (blanking) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwm_cmp_q <= 1'b0;
      oc_cmp_q  <= 1'b0;
    end else begin
      pwm_cmp_q <= pwm_cmp && !blanking && !(gate_edge && !edge_d); // RULE15
      oc_cmp_q  <= oc_cmp && !blanking && !(gate_edge && !edge_d);  // RULE15
    end
  end
  AST_BLANK_MASK: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE14
    (gate_edge && !edge_d) |=> !oc_cmp_q && !pwm_cmp_q)
    else $error("comparator passed at pulse start");
endmodule : cfhs_blank

// File: design/cfhs_seq.sv
`timescale 1ns/1ns
`include "cfhs_params.svh"
// Summary of operation
// [RULE1] Input overvoltage shuts down, low power about 295ms, then recovery.
// [RULE2] After the delay, soft-start if fault gone, else another full delay.
// [RULE3] Undervoltage shuts down without low power and without restart delay.
// [RULE4] Fault is reference low, overvoltage high or undervoltage low.
// [RULE5] During fault gate is off and soft-start is fast discharged.
// [RULE6] Soft-start begins only when fault is clear and ramp is reset low.
// [RULE7] Overcurrent shutdown armed only after soft-start completes.
// [RULE8] During soft-start overcurrent only ends the current gate pulse.
// [RULE9] Armed overcurrent turns charge off and 40uA discharge on.
// [RULE10] Overcurrent retriggers a one-shot lasting 50us past its end.
// [RULE11] Overcurrent discharge does not end while the one-shot runs.
// [RULE12] Ramp reaching 4.375V in discharge: output off, full discharge, low power.
// [RULE13] One-shot expiry before 4.375V restores charging without shutdown.
// [RULE14] Current sense ignored for first 100ns after gate leading edge.
// [RULE15] Blanking masks both pulse-width and overcurrent comparators.
// [RULE16] One-shot, restart delay and blanking counted from one clock.
module cfhs_seq
  import cfhs_pkg::*;
#(
  parameter int ONESHOT_CYC = `CFHS_ONESHOT_CYC,
  parameter int RESTART_CYC = `CFHS_RESTART_CYC,
  parameter int BLANK_CYC   = `CFHS_BLANK_CYC
) (
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic ref_low,
  input  wire logic input_over_limit_flag,
  input  wire logic input_under_limit_flag,
  input  wire logic overcurrent_cmp,
  input  wire logic pwm_cmp,
  input  wire logic gate_edge,
  input  wire logic ss_reset_low,
  input  wire logic ss_done,
  input  wire logic ss_below_trip,
  output logic      gate_enable,
  output logic      pulse_end,
  output logic      ss_charge,
  output logic      ss_slow_discharge,
  output logic      ss_fast_discharge,
  output logic      low_power,
  output logic      fault_flag,
  output cfhs_pkg::cfhs_state_e state_out
);
  import cfhs_pkg::*;
  localparam int OW = $clog2(ONESHOT_CYC + 1);
  localparam int RW = $clog2(RESTART_CYC + 1);
  initial begin
    if (ONESHOT_CYC < 1 || RESTART_CYC < 1) $error("timer counts must be at least 1");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [7:0] s1;
  logic [7:0] s2;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
    end else begin
      s1 <= {ss_below_trip, ss_done, ss_reset_low, gate_edge, pwm_cmp, overcurrent_cmp,
             input_under_limit_flag, input_over_limit_flag};
      s2 <= s1;
    end
  end
  logic over_s;
  logic under_s;
  logic ref_s1;
  logic ref_s2;
  logic ss_rst;
  logic ss_dn;
  logic ss_trip;
  logic fault;
  assign over_s  = s2[0];
  assign under_s = s2[1];
  assign ss_rst  = s2[5];
  assign ss_dn   = s2[6];
  assign ss_trip = s2[7];
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ref_s1 <= 1'b1;
      ref_s2 <= 1'b1;
    end else begin
      ref_s1 <= ref_low;
      ref_s2 <= ref_s1;
    end
  end
  assign fault = ref_s2 || over_s || under_s; // RULE4

  // ****************************************
  // Leading edge blanking
  // ****************************************
  logic pwm_b;
  logic oc_b;
  cfhs_blank #(.BLANK_CYC(BLANK_CYC)) u_blank (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .gate_edge (s2[4]),
    .pwm_cmp   (s2[3]),
    .oc_cmp    (s2[2]),
    .pwm_cmp_q (pwm_b),
    .oc_cmp_q  (oc_b)
  ); // RULE16

  // ****************************************
  // Retriggerable one-shot
  // ****************************************
  logic [OW-1:0] os_cnt;
  logic          os_active;
  assign os_active = oc_b || (os_cnt != '0);
  cfhs_state_e state;
  cfhs_state_e next_state;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      os_cnt <= '0;
    end else if (state != CFHS_RUN && state != CFHS_OC_DIS) begin
      os_cnt <= '0;
    end else if (oc_b) begin
      os_cnt <= OW'(ONESHOT_CYC); // RULE10
    end else if (os_cnt != '0) begin
      os_cnt <= os_cnt - 1'b1;
    end
  end

  // ****************************************
  // Restart delay
  // ****************************************
  logic [RW-1:0] rs_cnt;
  logic          rs_load;
  logic          rs_done;
  assign rs_done = (rs_cnt == RW'(1));
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rs_cnt <= '0;
    end else if (rs_load) begin
      rs_cnt <= RW'(RESTART_CYC); // RULE16
    end else if (rs_cnt != '0) begin
      rs_cnt <= rs_cnt - 1'b1;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Overvoltage takes priority: a combined fault still gets the delay
  always_comb begin
    next_state = state;
    rs_load    = 1'b0;
    unique case (state)
      CFHS_FAULT: begin
        if (over_s) begin
          next_state = CFHS_LOWPWR; // RULE1
          rs_load    = 1'b1;
        end else if (!fault && ss_rst) begin
          next_state = CFHS_SOFT; // RULE3 RULE6
        end
      end
      CFHS_SOFT: begin
        if (fault) next_state = CFHS_FAULT; // RULE5
        else if (ss_dn) next_state = CFHS_RUN; // RULE7
      end
      CFHS_RUN: begin
        if (fault) next_state = CFHS_FAULT;
        else if (oc_b) next_state = CFHS_OC_DIS; // RULE9
      end
      CFHS_OC_DIS: begin
        if (fault) begin
          next_state = CFHS_FAULT;
        end else if (ss_trip) begin
          next_state = CFHS_LOWPWR; // RULE12
          rs_load    = 1'b1;
        end else if (!os_active) begin
          next_state = CFHS_RUN; // RULE11 RULE13
        end
      end
      CFHS_LOWPWR: begin
        if (rs_done) begin
          if (fault) begin
            rs_load = 1'b1; // RULE2
          end else begin
            next_state = CFHS_FAULT; // RULE2
          end
        end
      end
      default: next_state = CFHS_FAULT;
    endcase
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) state <= CFHS_FAULT;
    else state <= next_state;
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gate_enable       <= 1'b0;
      pulse_end         <= 1'b0;
      ss_charge         <= 1'b0;
      ss_slow_discharge <= 1'b0;
      ss_fast_discharge <= 1'b1;
      low_power         <= 1'b0;
      fault_flag        <= 1'b0;
      state_out         <= CFHS_FAULT;
    end else begin
      gate_enable       <= (next_state == CFHS_SOFT || next_state == CFHS_RUN ||
                            next_state == CFHS_OC_DIS); // RULE5
      pulse_end         <= pwm_b || oc_b; // RULE8
      ss_charge         <= (next_state == CFHS_SOFT || next_state == CFHS_RUN);
      ss_slow_discharge <= (next_state == CFHS_OC_DIS); // RULE9
      ss_fast_discharge <= (next_state == CFHS_FAULT || next_state == CFHS_LOWPWR);
      low_power         <= (next_state == CFHS_LOWPWR); // RULE1
      fault_flag        <= fault; // RULE4
      state_out         <= next_state;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_FAULT_GATE: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE5
    fault |=> !gate_enable && ss_fast_discharge)
    else $error("gate on during fault");
  // The reference stage resets to fault but the flag resets clear: skip the release edge
  AST_FAULT_FLAG: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE4
    $past(arst_n) |-> fault_flag == $past(fault))
    else $error("fault flag wrong");
  AST_SOFT_NO_OC: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE7
    (state == CFHS_SOFT && !fault) |=> state != CFHS_OC_DIS && state != CFHS_LOWPWR)
    else $error("overcurrent shutdown during soft-start");
  AST_OC_SWAP: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE9
    (state == CFHS_RUN && oc_b && !fault) |=> ss_slow_discharge && !ss_charge)
    else $error("discharge not enabled on overcurrent");
  AST_OS_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE11
    (state == CFHS_OC_DIS && os_active && !fault && !ss_trip) |=> state == CFHS_OC_DIS)
    else $error("discharge ended while one-shot active");
  AST_OS_LEN: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE10
    (state == CFHS_RUN && oc_b) |=> os_cnt == OW'(ONESHOT_CYC))
    else $error("one-shot not retriggered");
  AST_TRIP_LP: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE12
    (state == CFHS_OC_DIS && ss_trip && !fault) |=> low_power && !gate_enable)
    else $error("no hiccup on trip");
  AST_RECOVER: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE13
    (state == CFHS_OC_DIS && !os_active && !ss_trip && !fault) |=> ss_charge)
    else $error("charging not restored");
  AST_OVER_LP: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE1
    (state == CFHS_FAULT && over_s) |=> low_power)
    else $error("overvoltage did not enter low power");
  AST_UNDER_NOLP: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE3
    (state == CFHS_FAULT && under_s && !over_s) |=> !low_power)
    else $error("undervoltage entered low power");
  AST_LP_REPEAT: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE2
    (state == CFHS_LOWPWR && rs_done && fault) |=>
      state == CFHS_LOWPWR && rs_cnt == RW'(RESTART_CYC))
    else $error("restart delay not repeated");
  AST_START: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE6
    (state == CFHS_SOFT && $past(state) != CFHS_SOFT) |-> !$past(fault) && $past(ss_rst))
    else $error("soft-start began with fault or ramp high");
  COV_OC_TRIP: cover property (@(posedge clk_sys) state == CFHS_OC_DIS ##1 state == CFHS_LOWPWR);
  COV_OC_RECOV: cover property (@(posedge clk_sys) state == CFHS_OC_DIS ##1 state == CFHS_RUN);
  COV_OVER_RETRY: cover property (@(posedge clk_sys) state == CFHS_LOWPWR && rs_done && fault);
  COV_RUN: cover property (@(posedge clk_sys) state == CFHS_SOFT ##1 state == CFHS_RUN);
endmodule : cfhs_seq

// File: shared/cfhs_params.svh
`ifndef CFHS_PARAMS_SVH
`define CFHS_PARAMS_SVH
// Timing figures, each in its own unit
`define CFHS_CLK_MHZ        100
`define CFHS_ONESHOT_US     50
`define CFHS_RESTART_MS     295
`define CFHS_BLANK_NS       100
// Cycle counts derived from the clock rate
`define CFHS_ONESHOT_CYC    (`CFHS_ONESHOT_US * `CFHS_CLK_MHZ)
`define CFHS_RESTART_CYC    (`CFHS_RESTART_MS * 1000 * `CFHS_CLK_MHZ)
`define CFHS_BLANK_CYC      ((`CFHS_BLANK_NS * `CFHS_CLK_MHZ + 999) / 1000)
`endif

// File: shared/cfhs_pkg.sv
package cfhs_pkg;
  typedef enum logic [2:0] {
    CFHS_FAULT   = 3'h0,
    CFHS_SOFT    = 3'h1,
    CFHS_RUN     = 3'h2,
    CFHS_OC_DIS  = 3'h3,
    CFHS_LOWPWR  = 3'h4
  } cfhs_state_e;
endpackage : cfhs_pkg

// File: sim/cfhs_seq_test.sv
`timescale 1ns/1ns
module cfhs_seq_test;
  import cfhs_pkg::*;
  // Short counts keep the run brief; expectations below derive from these
  localparam int ONE = 20;
  localparam int RST = 200;
  localparam int BLK = 10;
  logic        clk_sys, arst_n, ref_low, input_over_limit_flag, input_under_limit_flag;
  logic        overcurrent_cmp, pwm_cmp, gate_edge, ss_reset_low, ss_done, ss_below_trip;
  logic        gate_enable, pulse_end, ss_charge, ss_slow_discharge, ss_fast_discharge;
  logic        low_power, fault_flag;
  cfhs_state_e state_out;
  int          n_errors, samples_checked, seed, k, len;
  logic [7:0]  dut_out;
  logic [7:0]  m_out;
  logic [8:0]  syn;
  logic [8:0]  pin_q[$];
  int          m_state, m_next, m_os, m_rs, m_blank, m_edge, m_oc, m_pwm, m_end, m_flag;
  int          m_fault, m_busy, m_load, m_mask;

  assign dut_out = {1'b0, gate_enable, ss_charge, ss_slow_discharge, ss_fast_discharge,
                    low_power, fault_flag, pulse_end};

  cfhs_seq #(.ONESHOT_CYC(ONE), .RESTART_CYC(RST), .BLANK_CYC(BLK)) i_cfhs_seq (
    .clk_sys(clk_sys), .arst_n(arst_n), .ref_low(ref_low),
    .input_over_limit_flag(input_over_limit_flag),
    .input_under_limit_flag(input_under_limit_flag),
    .overcurrent_cmp(overcurrent_cmp), .pwm_cmp(pwm_cmp), .gate_edge(gate_edge),
    .ss_reset_low(ss_reset_low), .ss_done(ss_done), .ss_below_trip(ss_below_trip),
    .gate_enable(gate_enable), .pulse_end(pulse_end), .ss_charge(ss_charge),
    .ss_slow_discharge(ss_slow_discharge), .ss_fast_discharge(ss_fast_discharge),
    .low_power(low_power), .fault_flag(fault_flag), .state_out(state_out));

  // ****************************************
  // Clock and shared tasks
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait, so a stuck sequencer shows up as a mismatch, not a hang
  task automatic wait_st(input cfhs_state_e s, input int n);
    int i;
    for (i = 0; i < n && state_out !== s; i++) begin
      @(negedge clk_sys);
    end
    chk(8'(state_out), 8'(s));
  endtask : wait_st

  task automatic oc_pulse(input int n);
    overcurrent_cmp = 1'b1;
    cyc(n);
    overcurrent_cmp = 1'b0;
  endtask : oc_pulse

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // More than ten times the length of the scenarios below
  initial begin
    repeat (40 * RST + 2000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end

  // ****************************************
  // Reference model
  // ****************************************
  // Pins reach the sequencer two edges late; the queue stands in for the synchronisers
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_q.delete();
      pin_q.push_back(9'h100); // Reference stage resets to the fault level
      pin_q.push_back(9'h100);
      m_state = 0;
      m_os    = 0;
      m_rs    = 0;
      m_blank = 0;
      m_edge  = 0;
      m_oc    = 0;
      m_pwm   = 0;
      m_end   = 0;
      m_flag  = 0;
    end else begin
      pin_q.push_back({ref_low, ss_below_trip, ss_done, ss_reset_low, gate_edge, pwm_cmp,
                       overcurrent_cmp, input_under_limit_flag, input_over_limit_flag});
      syn     = pin_q.pop_front();
      m_fault = syn[8] || syn[0] || syn[1];
      m_busy  = m_oc || m_os != 0;
      m_load  = 0;
      m_next  = m_state;
      case (m_state)
        0: begin
          if (syn[0]) begin
            m_next = 4;
            m_load = 1;
          end else if (!m_fault && syn[5]) begin
            m_next = 1;
          end
        end
        1: m_next = m_fault ? 0 : (syn[6] ? 2 : 1);
        2: m_next = m_fault ? 0 : (m_oc ? 3 : 2);
        3: begin
          if (m_fault) begin
            m_next = 0;
          end else if (syn[7]) begin
            m_next = 4;
            m_load = 1;
          end else if (!m_busy) begin
            m_next = 2;
          end
        end
        default: begin
          if (m_rs == 1 && m_fault) begin
            m_load = 1;
          end else if (m_rs == 1) begin
            m_next = 0;
          end
        end
      endcase
      if (m_state != 2 && m_state != 3) m_os = 0;
      else if (m_oc) m_os = ONE;
      else if (m_os != 0) m_os--;
      if (m_load) m_rs = RST;
      else if (m_rs != 0) m_rs--;
      m_end   = m_oc || m_pwm;
      m_mask  = (syn[4] && !m_edge) || m_blank != 0;
      if (syn[4] && !m_edge) m_blank = BLK;
      else if (m_blank != 0) m_blank--;
      m_edge  = syn[4];
      m_oc    = syn[2] && !m_mask;
      m_pwm   = syn[3] && !m_mask;
      m_flag  = m_fault;
      m_state = m_next;
    end
    m_out = {1'b0, m_state inside {1, 2, 3}, m_state inside {1, 2}, m_state == 3,
             m_state inside {0, 4}, m_state == 4, m_flag[0], m_end[0]};
  end

  // Every settled cycle is held against the model
  always @(negedge clk_sys) begin
    if (arst_n === 1'b1) begin
      chk(8'(state_out), 8'(m_state));
      chk(dut_out, m_out);
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 58;
    n_errors = 0;
    samples_checked = 0;
    {ref_low, input_over_limit_flag, input_under_limit_flag} = 3'h0;
    {overcurrent_cmp, pwm_cmp, gate_edge, ss_done, ss_below_trip} = 5'h0;
    ss_reset_low = 1'b1;
    arst_n = 1'b0;
    cyc(6);
    arst_n = 1'b1;
    wait_st(CFHS_SOFT, 10);
    chk(ss_charge, 1'b1);
    $display("test reset done");
    // Reference low and undervoltage: shutdown without the delay
    for (k = 0; k < 2; k++) begin
      if (k == 0) ref_low = 1'b1;
      else input_under_limit_flag = 1'b1;
      cyc(6);
      chk(fault_flag, 1'b1);
      chk(gate_enable, 1'b0);
      chk(ss_fast_discharge, 1'b1);
      chk(low_power, 1'b0);
      ss_reset_low = 1'b0;
      {ref_low, input_under_limit_flag} = 2'h0;
      cyc(10);
      chk(8'(state_out), 8'(CFHS_FAULT));
      ss_reset_low = 1'b1;
      wait_st(CFHS_SOFT, 6);
    end
    $display("test fault sources done");
    // Overvoltage held past one interval forces a second full interval
    input_over_limit_flag = 1'b1;
    cyc(5);
    chk(fault_flag, 1'b1);
    chk(8'(state_out), 8'(CFHS_LOWPWR));
    chk(low_power, 1'b1);
    chk(gate_enable, 1'b0);
    cyc(RST + 95);
    input_over_limit_flag = 1'b0;
    cyc(50);
    chk(8'(state_out), 8'(CFHS_LOWPWR));
    wait_st(CFHS_SOFT, 120);
    $display("test overvoltage done");
    // Overcurrent during soft-start only ends the pulse
    overcurrent_cmp = 1'b1;
    cyc(8);
    chk(8'(state_out), 8'(CFHS_SOFT));
    chk(pulse_end, 1'b1);
    overcurrent_cmp = 1'b0;
    ss_done = 1'b1;
    wait_st(CFHS_RUN, 8);
    // Retriggered one-shot, then recovery without shutdown
    len = 1 + ($unsigned($random(seed)) % 4);
    oc_pulse(len);
    cyc(5);
    chk(8'(state_out), 8'(CFHS_OC_DIS));
    chk(ss_slow_discharge, 1'b1);
    chk(ss_charge, 1'b0);
    cyc(10);
    oc_pulse(1 + ($unsigned($random(seed)) % 4));
    cyc(ONE - 4);
    chk(8'(state_out), 8'(CFHS_OC_DIS));
    wait_st(CFHS_RUN, 14);
    chk(ss_charge, 1'b1);
    $display("test oc recovery done");
    // Ramp falls to the trip level during discharge: hiccup
    oc_pulse(2);
    cyc(5);
    ss_below_trip = 1'b1;
    cyc(5);
    chk(8'(state_out), 8'(CFHS_LOWPWR));
    chk(gate_enable, 1'b0);
    chk(ss_fast_discharge, 1'b1);
    ss_below_trip = 1'b0;
    ss_done = 1'b0;
    cyc(RST - 30);
    chk(low_power, 1'b1);
    wait_st(CFHS_SOFT, 60);
    $display("test oc hiccup done");
    // Comparators inside the blanking window are ignored
    ss_done = 1'b1;
    wait_st(CFHS_RUN, 8);
    gate_edge = 1'b1;
    cyc(1);
    {pwm_cmp, overcurrent_cmp} = 2'h3;
    cyc(5);
    chk(pulse_end, 1'b0);
    overcurrent_cmp = 1'b0;
    cyc(12);
    chk(8'(state_out), 8'(CFHS_RUN));
    chk(pulse_end, 1'b1);
    {pwm_cmp, gate_edge} = 2'h0;
    $display("test blanking done");
    final_report();
  end
endmodule : cfhs_seq_test
